// File: dv/bgst_ser_model.sv
// Purpose: Serializer-side model that sends forward frames for the SPI tunnel
// Assumes: One forward frame every GAP clocks, samples taken from the controller lines
// Notes: Between frames the sample lines show the inverse of the last frame
`timescale 1ns/1ps
module bgst_ser_model #(
  parameter int GAP = 4
) (
  input wire logic clk,
  input wire logic [2:0] src,
  output logic frame_valid,
  output logic [2:0] fwd_sample
);
  int cnt = 0;
  logic [2:0] last = 3'h7;
  // Idle values before the first edge
  initial
  begin
    frame_valid = 1'b0;
    fwd_sample = 3'h0;
  end
  // One sample of clock, data and select per frame
  always @(posedge clk)
  begin
    cnt <= (cnt + 1) % GAP;
    frame_valid <= (cnt == GAP - 1);
    if (cnt == GAP - 1)
    begin
      last <= src;
      fwd_sample <= src;
    end
    else
      fwd_sample <= ~last;
  end
endmodule

// File: dv/bgst_top_tb_top.sv
// Purpose: Self-checking bench for back channel rate, GPIO, side channel and SPI tunnel
// Assumes: Byte register port, strap high, dual lane, serializer model as frame source
// Notes: FRAME_CYC is cut to 16 so frame waits stay short
`timescale 1ns/1ps
module bgst_top_tb_top;
  logic CLK_SYS = 1'b0, RESET = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0, REG_RVALID;
  logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA;
  logic STRAP_HIGHSPEED = 1'b1, DUAL_LANE = 1'b1, GPIO9_IN = 1'b0, GPIO9_OUT, GPIO9_OE;
  logic [3:0] GPIO_PRI_IN = 4'hF, GPIO_SEC_IN = 4'hF, GPIO_REG_IN = 4'h6;
  logic [3:0] GPIO_PRI_OUT, GPIO_PRI_OE, GPIO_SEC_OUT, GPIO_SEC_OE, GPIO_REG_OUT, GPIO_REG_OE;
  logic [3:0] AUDIO_IN_OVERRIDE, BC_GPIO_SAMPLE;
  logic BC_BIT_STROBE, BC_FRAME_TICK, BC_SEND_STATUS, BC_GPIO_VALID, FWD_FRAME_VALID;
  logic SPI_POCI = 1'b0, SPI_CLK, SPI_PICO, SPI_SEL_N, LINK_POCI, REV_SPI_SEL_N = 1'b1;
  logic BC_REV_SEL_N;
  logic [2:0] fwd;
  logic [2:0] ctl_src = 3'h1;
  logic [7:0] d, gp;
  logic [7:0] rate_w [4] = '{8'h00, 8'h40, 8'h50, 8'h10};
  logic [7:0] rate_p [4] = '{8'h04, 8'h02, 8'h01, 8'h01};
  logic [3:0] sample_exp [4] = '{4'hA, 4'h1, 4'h3, 4'hF};
  logic [7:0] status_exp = 8'h31;
  int n_fail = 0, tests_run = 0;

  bgst_top #(.FRAME_CYC(16)) DUT (
    .CLK_SYS, .RESET, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .REG_RVALID,
    .STRAP_HIGHSPEED, .DUAL_LANE, .GPIO_PRI_IN, .GPIO_PRI_OUT, .GPIO_PRI_OE, .GPIO_SEC_IN,
    .GPIO_SEC_OUT, .GPIO_SEC_OE, .GPIO_REG_IN, .GPIO_REG_OUT, .GPIO_REG_OE,
    .AUDIO_IN_OVERRIDE, .GPIO9_IN, .GPIO9_OUT, .GPIO9_OE, .BC_BIT_STROBE, .BC_FRAME_TICK,
    .BC_SEND_STATUS, .BC_GPIO_SAMPLE, .BC_GPIO_VALID, .FWD_FRAME_VALID,
    .FWD_SPI_CLK(fwd[2]), .FWD_SPI_PICO(fwd[1]), .FWD_SPI_SEL_N(fwd[0]), .SPI_POCI,
    .SPI_CLK, .SPI_PICO, .SPI_SEL_N, .LINK_POCI, .REV_SPI_SEL_N, .BC_REV_SEL_N
  );
  bgst_ser_model #(.GAP(4)) partner (
    .clk(CLK_SYS), .src(ctl_src), .frame_valid(FWD_FRAME_VALID), .fwd_sample(fwd)
  );

  // 50 MHz system clock
  always #10 CLK_SYS = ~CLK_SYS;

  // Bench steps sit just after the rising edge
  task automatic tick();
    @(posedge CLK_SYS);
    #1;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Write strobe for one cycle, return once the outputs follow
  task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
    REG_ADDR = a;
    REG_WDATA = v;
    REG_WR = 1'b1;
    tick();
    REG_WR = 1'b0;
    repeat (2) tick();
  endtask

  // Read strobe for one cycle, data taken while the valid pulse stands
  task automatic reg_read(input logic [7:0] a, output logic [7:0] v);
    REG_ADDR = a;
    REG_RD = 1'b1;
    tick();
    v = REG_RDATA;
    check("read_valid", {7'h0, REG_RVALID}, 8'h01);
    REG_RD = 1'b0;
    tick();
  endtask

  // Cycles between two back channel bit strobes
  task automatic gap(output logic [7:0] g);
    g = 8'h00;
    for (int i = 0; i < 9 && BC_BIT_STROBE !== 1'b1; i++) tick();
    do
    begin
      tick();
      g++;
    end
    while (BC_BIT_STROBE !== 1'b1 && g < 8'h09);
  endtask

  task automatic wait_frame();
    tick();
    for (int i = 0; i < 8 && FWD_FRAME_VALID !== 1'b1; i++) tick();
  endtask

  task automatic end_of_test();
    if (n_fail == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog against a hang
  initial
  begin
    #400000;
    n_fail++;
    end_of_test();
  end

  // Main sequence
  initial
  begin
    repeat (5) tick();
    RESET = 1'b0;
    repeat (2) tick();
    reg_read(8'h23, d);
    check("rate_ctl", d, 8'h10);
    foreach (rate_w[k])
    begin
      reg_write(8'h23, rate_w[k]);
      gap(gp);
      gap(gp);
      check("bit_gap", gp, rate_p[k]);
    end
    reg_write(8'h1D, 8'h09);
    check("pri_gpio0", {GPIO_PRI_OE, GPIO_PRI_OUT} & 8'h11, 8'h11);
    reg_write(8'h1D, 8'h01);
    check("pri_gpio0", {GPIO_PRI_OE, GPIO_PRI_OUT} & 8'h11, 8'h10);
    reg_write(8'h1D, 8'h03);
    reg_write(8'h1E, 8'h33);
    reg_write(8'h1F, 8'h03);
    GPIO_PRI_IN = 4'hA;
    reg_read(8'h6E, d);
    check("status_low", {GPIO_PRI_OE, d[3:0]}, 8'h0A);
    reg_write(8'h34, 8'h02);
    reg_write(8'h1D, 8'h09);
    GPIO_SEC_IN = 4'h5;
    reg_read(8'h6E, d);
    check("sec_gpio", {GPIO_SEC_OE[0], GPIO_SEC_OUT[0], GPIO_PRI_OE[0], 1'b0, d[3:0]},
      8'hC5);
    reg_write(8'h34, 8'h01);
    GPIO_SEC_IN = 4'hF;
    reg_write(8'h20, 8'h39);
    reg_write(8'h21, 8'h13);
    reg_write(8'h1A, 8'h03);
    GPIO9_IN = 1'b1;
    check("reg_gpio", {GPIO_REG_OE, GPIO_REG_OUT & 4'h9}, 8'h91);
    check("audio_ovr", {3'h0, GPIO9_OE, AUDIO_IN_OVERRIDE}, 8'h0F);
    reg_write(8'h1A, 8'h09);
    check("gpio9_drive", {6'h0, GPIO9_OE, GPIO9_OUT}, 8'h03);
    reg_read(8'h6E, d);
    check("status_low", d & 8'hC0, 8'hC0);
    reg_read(8'h6F, d);
    check("status_high", d & 8'h02, 8'h02);
    reg_read(8'h55, d);
    check("unmapped", d, 8'h00);
    // Every side channel code from normal upwards, with lane samples for the GPIO modes
    for (int c = 0; c < 8; c++)
    begin
      reg_write(8'h43, c[7:0]);
      reg_read(8'h43, d);
      check("mode_reg", d, c[7:0]);
      check("send_status", {7'h0, BC_SEND_STATUS}, {7'h0, status_exp[c]});
      if (c < 4)
      begin
        for (int i = 0; i < 40 && BC_GPIO_VALID !== 1'b1; i++) tick();
        check("gpio_sample", {4'h0, BC_GPIO_SAMPLE}, {4'h0, sample_exp[c]});
      end
    end
    REV_SPI_SEL_N = 1'b0;
    tick();
    for (int i = 0; i < 40 && BC_FRAME_TICK !== 1'b1; i++) tick();
    check("rev_sel", {7'h0, BC_REV_SEL_N}, 8'h00);
    REV_SPI_SEL_N = 1'b1;
    tick();
    for (int i = 0; i < 40 && BC_FRAME_TICK !== 1'b1; i++) tick();
    check("rev_sel", {7'h0, BC_REV_SEL_N}, 8'h01);
    // Forward tunnel: data first, clock one cycle later, peripheral data frozen
    reg_write(8'h43, 8'h06);
    ctl_src = 3'h2;
    wait_frame();
    repeat (2) tick();
    check("spi_fwd", {6'h0, SPI_PICO, SPI_SEL_N}, 8'h02);
    ctl_src = 3'h4;
    wait_frame();
    tick();
    check("spi_lag", {6'h0, SPI_CLK, SPI_PICO}, 8'h00);
    tick();
    SPI_POCI = 1'b1;
    check("spi_clk", {7'h0, SPI_CLK}, 8'h01);
    repeat (2) tick();
    check("poci_hold", {7'h0, LINK_POCI}, 8'h00);
    // Clock low again: peripheral data passes through
    ctl_src = 3'h0;
    wait_frame();
    repeat (3) tick();
    check("poci_pass", {7'h0, LINK_POCI}, 8'h01);
    DUAL_LANE = 1'b0;
    repeat (3) tick();
    check("single_lane", {6'h0, SPI_CLK, SPI_SEL_N}, 8'h01);
    end_of_test();
  end
endmodule

// File: hw/bgst_pkg.sv
// Purpose: Shared constants and types of the back-channel, GPIO and SPI tunnel block
// Assumes: Byte-wide register port at the printed offsets, one system clock
// Notes: Fields are kept as position constants; reserved bits read as zero
package bgst_pkg;
  // Register offsets
  localparam logic [7:0] OFS_GPIO9_CONFIG = 8'h1A;
  localparam logic [7:0] OFS_GPIO0_CONFIG = 8'h1D;
  localparam logic [7:0] OFS_GPIO1_2_CONFIG = 8'h1E;
  localparam logic [7:0] OFS_GPIO3_CONFIG = 8'h1F;
  localparam logic [7:0] OFS_REG_GPIO5_6_CONFIG = 8'h20;
  localparam logic [7:0] OFS_REG_GPIO7_8_CONFIG = 8'h21;
  localparam logic [7:0] OFS_BACKCHANNEL_RATE_CONTROL = 8'h23;
  localparam logic [7:0] OFS_PORT_SELECT = 8'h34;
  localparam logic [7:0] OFS_SIDE_CHANNEL_CONTROL = 8'h43;
  localparam logic [7:0] OFS_GPIO_INPUT_STATUS_LOW = 8'h6E;
  localparam logic [7:0] OFS_GPIO_INPUT_STATUS_HIGH = 8'h6F;
  // Field positions
  localparam int POS_RATE_SELECT = 6;
  localparam int POS_HIGHSPEED_ENABLE = 4;
  localparam int POS_PRIMARY_PORT_SELECT = 0;
  localparam int POS_SECONDARY_PORT_SELECT = 1;
  localparam int POS_STATUS_REG_GPIO5 = 5;
  localparam int POS_STATUS_GPIO8 = 0;
  localparam int POS_STATUS_GPIO9 = 1;
  // Reset values
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [1:0] RST_PORT_SELECT = 2'h1;
  localparam logic [2:0] RST_SIDE_CHANNEL_MODE = 3'h0;
  // Local GPIO configuration codes
  localparam logic [3:0] CFG_OUT_LOW = 4'h1;
  localparam logic [3:0] CFG_OUT_HIGH = 4'h9;
  localparam logic [3:0] CFG_INPUT = 4'h3;
  // Side channel mode codes
  localparam logic [2:0] CODE_NORMAL = 3'h0;
  localparam logic [2:0] CODE_FAST1 = 3'h1;
  localparam logic [2:0] CODE_FAST2 = 3'h2;
  localparam logic [2:0] CODE_FAST4 = 3'h3;
  localparam logic [2:0] CODE_SPI_FWD = 3'h6;
  localparam logic [2:0] CODE_SPI_REV = 3'h7;
  // Oscillator dividers for the back channel bit clock
  localparam logic [1:0] DIV_SLOW = 2'h3;
  localparam logic [1:0] DIV_MID = 2'h1;
  localparam logic [1:0] DIV_FAST = 2'h0;
  // Nominal back channel rates, Mbps
  localparam int RATE_SLOW_MBPS = 5;
  localparam int RATE_MID_MBPS = 10;
  localparam int RATE_FAST_MBPS = 20;
  // Back channel frame period at the slowest rate
  localparam int CLK_SYS_MHZ = 50;
  localparam int SLOW_FRAME_NS = 7500;
  localparam int SLOW_FRAME_CYC = (SLOW_FRAME_NS * CLK_SYS_MHZ + 999) / 1000;
  typedef enum {
    BGST_NORMAL, BGST_FAST4, BGST_FAST2, BGST_FAST1, BGST_SPI_FWD, BGST_SPI_REV
  } bgst_mode_type;
endpackage

// File: hw/bgst_top.sv
// Purpose: Side-band logic: back channel rate, fast side channel, local GPIO, SPI tunnel
// Assumes: All inputs synchronous to CLK_SYS; CLK_SYS stands in for the oscillator
// Notes: Forward frame samples arrive as one-cycle strobes from the pixel side
//
// Contract
// (RULE1) Oscillator divided by four when rate select is 0, by two when 1.
// (RULE2) High-speed clear: back channel runs at 5 or 10 Mbps by rate select.
// (RULE3) High-speed set: rate select ignored, divider one, 20 Mbps.
// (RULE4) High-speed enable preset from a strap after reset, also register writable.
// (RULE5) System sets 5 Mbps when paired with an older serializer.
// (RULE6) Fast side channel replaces ID, capability and lock content by samples.
// (RULE7) Software selects fast modes only after lock in normal mode.
// (RULE8) Mode 000 four GPIOs one sample, 011 4x6, 010 2x10, 001 1x15.
// (RULE9) Lane GPIO bandwidth rated at slow worst rate with fourfold oversampling.
// (RULE10) Back channel rate may spread twenty percent; sampling logic tolerates it.
// (RULE11) Register GPIOs five to eight drive or read; take over audio inputs.
// (RULE12) Config nibble 0x1 drives low, 0x9 drives high, 0x3 input with status.
// (RULE13) GPIO5-8 configs at 0x20/0x21, status 0x6E[7:5], 0x6F[0]; GPIO9 0x1A, 0x6F[1].
// (RULE14) GPIO0-3 configs at 0x1D to 0x1F, status at 0x6E[3:0].
// (RULE15) Register GPIO state is never forwarded over the link.
// (RULE16) SPI tunnel only on the secondary lane in dual-lane operation.
// (RULE17) Controller read clock period exceeds link round trip latency.
// (RULE18) Controller writes may run fast and ignore peripheral-out data.
// (RULE19) Tunnelled SPI never reaches any register.
// (RULE20) Mode 110 is forward SPI, 111 is reverse SPI.
// (RULE21) Forward SPI samples are regenerated one per forward frame.
// (RULE22) Peripheral-out held while clock high; clock delayed one cycle after data.
// (RULE23) Undefined mode codes act as normal back channel operation.
// (RULE24) Port select bits steer GPIO0-3 configs to primary or secondary lane.
// (RULE25) Reverse select high is reported for at least one back channel frame.
`timescale 1ns/1ps
module bgst_top #(
  parameter int FRAME_CYC = bgst_pkg::SLOW_FRAME_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  input wire logic STRAP_HIGHSPEED,
  input wire logic DUAL_LANE,
  input wire logic [3:0] GPIO_PRI_IN,
  output logic [3:0] GPIO_PRI_OUT,
  output logic [3:0] GPIO_PRI_OE,
  input wire logic [3:0] GPIO_SEC_IN,
  output logic [3:0] GPIO_SEC_OUT,
  output logic [3:0] GPIO_SEC_OE,
  input wire logic [3:0] GPIO_REG_IN,
  output logic [3:0] GPIO_REG_OUT,
  output logic [3:0] GPIO_REG_OE,
  output logic [3:0] AUDIO_IN_OVERRIDE,
  input wire logic GPIO9_IN,
  output logic GPIO9_OUT,
  output logic GPIO9_OE,
  output logic BC_BIT_STROBE,
  output logic BC_FRAME_TICK,
  output logic BC_SEND_STATUS,
  output logic [3:0] BC_GPIO_SAMPLE,
  output logic BC_GPIO_VALID,
  input wire logic FWD_FRAME_VALID,
  input wire logic FWD_SPI_CLK,
  input wire logic FWD_SPI_PICO,
  input wire logic FWD_SPI_SEL_N,
  input wire logic SPI_POCI,
  output logic SPI_CLK,
  output logic SPI_PICO,
  output logic SPI_SEL_N,
  output logic LINK_POCI,
  input wire logic REV_SPI_SEL_N,
  output logic BC_REV_SEL_N
);
  // Frame counter is ten bits and the fast rate shifts by two, so bound the period
  if (FRAME_CYC < 8 || FRAME_CYC > 1023)
    $error("FRAME_CYC out of range");

  typedef struct packed {
    logic strap_done;
    logic highspeed;
    logic rate_sel;
    logic [2:0] mode;
    logic [1:0] port_sel;
    logic [2:0][7:0] cfg_pri;
    logic [2:0][7:0] cfg_sec;
    logic [7:0] cfg9;
    logic [1:0][7:0] cfg_reg;
    logic [1:0] div_cnt;
    logic [9:0] frame_cnt;
    logic [3:0] samp_cnt;
    logic spi_clk_pre;
    logic [7:0] rdata;
    logic rvalid;
    logic [3:0] pri_out;
    logic [3:0] pri_oe;
    logic [3:0] sec_out;
    logic [3:0] sec_oe;
    logic [3:0] reg_out;
    logic [3:0] reg_oe;
    logic [3:0] audio_ovr;
    logic g9_out;
    logic g9_oe;
    logic bit_strobe;
    logic frame_tick;
    logic send_status;
    logic [3:0] gpio_sample;
    logic gpio_valid;
    logic spi_clk;
    logic spi_pico;
    logic spi_sel_n;
    logic link_poci;
    logic rev_sel_n;
  } bgst_state_type;

  bgst_state_type st_reg;
  bgst_state_type st_next;

  // Mode decode; unlisted codes fall back to normal
  function automatic bgst_pkg::bgst_mode_type decode_mode(input logic [2:0] code);
    unique case (code)
      bgst_pkg::CODE_FAST4: decode_mode = bgst_pkg::BGST_FAST4;
      bgst_pkg::CODE_FAST2: decode_mode = bgst_pkg::BGST_FAST2;
      bgst_pkg::CODE_FAST1: decode_mode = bgst_pkg::BGST_FAST1;
      bgst_pkg::CODE_SPI_FWD: decode_mode = bgst_pkg::BGST_SPI_FWD; // RULE20
      bgst_pkg::CODE_SPI_REV: decode_mode = bgst_pkg::BGST_SPI_REV; // RULE20
      default: decode_mode = bgst_pkg::BGST_NORMAL; // RULE23
    endcase
  endfunction

  // Samples per back channel frame and lane GPIO mask per mode
  function automatic logic [3:0] samples_per_frame(input bgst_pkg::bgst_mode_type m);
    unique case (m)
      bgst_pkg::BGST_FAST4: samples_per_frame = 4'h6; // RULE8
      bgst_pkg::BGST_FAST2: samples_per_frame = 4'hA; // RULE8
      bgst_pkg::BGST_FAST1: samples_per_frame = 4'hF; // RULE8
      default: samples_per_frame = 4'h1; // RULE8
    endcase
  endfunction

  function automatic logic [3:0] lane_mask(input bgst_pkg::bgst_mode_type m);
    unique case (m)
      bgst_pkg::BGST_FAST2: lane_mask = 4'h3; // RULE8
      bgst_pkg::BGST_FAST1: lane_mask = 4'h1; // RULE8
      default: lane_mask = 4'hF; // RULE8
    endcase
  endfunction

  // Nibble of GPIO k (0..3) within the three lane config bytes
  function automatic logic [3:0] lane_nib(input logic [2:0][7:0] cfg, input int k);
    unique case (k)
      0: lane_nib = cfg[0][3:0];
      1: lane_nib = cfg[1][3:0];
      2: lane_nib = cfg[1][7:4];
      default: lane_nib = cfg[2][3:0];
    endcase
  endfunction

  function automatic logic nib_oe(input logic [3:0] n);
    nib_oe = (n == bgst_pkg::CFG_OUT_LOW) || (n == bgst_pkg::CFG_OUT_HIGH); // RULE12
  endfunction

  function automatic logic nib_used(input logic [3:0] n);
    nib_used = nib_oe(n) || (n == bgst_pkg::CFG_INPUT); // RULE12
  endfunction

  bgst_pkg::bgst_mode_type mode_now;
  logic [1:0] div_now;
  logic [7:0] status_low;
  logic [7:0] status_high;
  logic fast_gpio;
  logic spi_fwd_on;
  logic spi_rev_on;

  // Derived views of the current state
  always_comb
  begin
    mode_now = decode_mode(st_reg.mode);
    fast_gpio = (mode_now == bgst_pkg::BGST_FAST4) || (mode_now == bgst_pkg::BGST_FAST2)
      || (mode_now == bgst_pkg::BGST_FAST1);
    spi_fwd_on = (mode_now == bgst_pkg::BGST_SPI_FWD) && DUAL_LANE; // RULE16
    spi_rev_on = (mode_now == bgst_pkg::BGST_SPI_REV) && DUAL_LANE; // RULE16
    if (st_reg.highspeed)
      div_now = bgst_pkg::DIV_FAST; // RULE3
    else if (st_reg.rate_sel)
      div_now = bgst_pkg::DIV_MID; // RULE1 RULE2
    else
      div_now = bgst_pkg::DIV_SLOW; // RULE1 RULE2
    // Status shows the pins of the lane chosen by the port select bits
    status_low = 8'h00;
    status_low[3:0] = st_reg.port_sel[bgst_pkg::POS_SECONDARY_PORT_SELECT] ? GPIO_SEC_IN
      : GPIO_PRI_IN; // RULE14 RULE24
    status_low[bgst_pkg::POS_STATUS_REG_GPIO5 +: 3] = GPIO_REG_IN[2:0]; // RULE13
    status_high = 8'h00;
    status_high[bgst_pkg::POS_STATUS_GPIO8] = GPIO_REG_IN[3]; // RULE13
    status_high[bgst_pkg::POS_STATUS_GPIO9] = GPIO9_IN; // RULE13
  end

  // Next state: registers, back channel timing, GPIO drive and SPI regeneration
  always_comb
  begin
    st_next = st_reg;
    st_next.rvalid = 1'b0;
    st_next.bit_strobe = 1'b0;
    st_next.frame_tick = 1'b0;
    st_next.gpio_valid = 1'b0;
    // Strap preset on the first cycle after reset release
    if (!st_reg.strap_done)
    begin
      st_next.strap_done = 1'b1;
      st_next.highspeed = STRAP_HIGHSPEED; // RULE4
    end
    // Register writes; the tunnel has no path into this decode
    if (REG_WR) // RULE19
    begin
      unique case (REG_ADDR)
        bgst_pkg::OFS_GPIO9_CONFIG: st_next.cfg9 = REG_WDATA; // RULE13
        bgst_pkg::OFS_GPIO0_CONFIG, bgst_pkg::OFS_GPIO1_2_CONFIG, bgst_pkg::OFS_GPIO3_CONFIG:
        begin
          if (st_reg.port_sel[bgst_pkg::POS_PRIMARY_PORT_SELECT])
            st_next.cfg_pri[REG_ADDR[1:0] - 2'h1] = REG_WDATA; // RULE14 RULE24
          if (st_reg.port_sel[bgst_pkg::POS_SECONDARY_PORT_SELECT])
            st_next.cfg_sec[REG_ADDR[1:0] - 2'h1] = REG_WDATA; // RULE24
        end
        bgst_pkg::OFS_REG_GPIO5_6_CONFIG: st_next.cfg_reg[0] = REG_WDATA; // RULE13
        bgst_pkg::OFS_REG_GPIO7_8_CONFIG: st_next.cfg_reg[1] = REG_WDATA; // RULE13
        bgst_pkg::OFS_BACKCHANNEL_RATE_CONTROL:
        begin
          st_next.rate_sel = REG_WDATA[bgst_pkg::POS_RATE_SELECT];
          st_next.highspeed = REG_WDATA[bgst_pkg::POS_HIGHSPEED_ENABLE]; // RULE4
        end
        bgst_pkg::OFS_PORT_SELECT: st_next.port_sel = REG_WDATA[1:0];
        bgst_pkg::OFS_SIDE_CHANNEL_CONTROL: st_next.mode = REG_WDATA[2:0];
        default: ;
      endcase
    end
    // Register reads, answered one cycle later
    if (REG_RD)
    begin
      st_next.rvalid = 1'b1;
      unique case (REG_ADDR)
        bgst_pkg::OFS_GPIO9_CONFIG: st_next.rdata = st_reg.cfg9;
        bgst_pkg::OFS_GPIO0_CONFIG, bgst_pkg::OFS_GPIO1_2_CONFIG, bgst_pkg::OFS_GPIO3_CONFIG:
          st_next.rdata = st_reg.port_sel[bgst_pkg::POS_SECONDARY_PORT_SELECT]
            ? st_reg.cfg_sec[REG_ADDR[1:0] - 2'h1] : st_reg.cfg_pri[REG_ADDR[1:0] - 2'h1];
        bgst_pkg::OFS_REG_GPIO5_6_CONFIG: st_next.rdata = st_reg.cfg_reg[0];
        bgst_pkg::OFS_REG_GPIO7_8_CONFIG: st_next.rdata = st_reg.cfg_reg[1];
        bgst_pkg::OFS_BACKCHANNEL_RATE_CONTROL:
        begin
          st_next.rdata = 8'h00;
          st_next.rdata[bgst_pkg::POS_RATE_SELECT] = st_reg.rate_sel;
          st_next.rdata[bgst_pkg::POS_HIGHSPEED_ENABLE] = st_reg.highspeed;
        end
        bgst_pkg::OFS_PORT_SELECT: st_next.rdata = {6'h00, st_reg.port_sel};
        bgst_pkg::OFS_SIDE_CHANNEL_CONTROL: st_next.rdata = {5'h00, st_reg.mode};
        bgst_pkg::OFS_GPIO_INPUT_STATUS_LOW: st_next.rdata = status_low; // RULE12 RULE14
        bgst_pkg::OFS_GPIO_INPUT_STATUS_HIGH: st_next.rdata = status_high; // RULE13
        default: st_next.rdata = 8'h00;
      endcase
    end
    // Bit clock: oscillator divided by 4, 2 or 1
    if (st_reg.div_cnt >= div_now)
    begin
      st_next.div_cnt = 2'h0;
      st_next.bit_strobe = 1'b1; // RULE1 RULE3
    end
    else
      st_next.div_cnt = st_reg.div_cnt + 2'h1;
    // Frame timer scales with the divider so a frame holds a fixed bit count
    if (st_reg.frame_cnt >= 10'((FRAME_CYC >> (2 - int'(div_now[1]) - int'(div_now[0]))) - 1))
    begin
      st_next.frame_cnt = 10'h000;
      st_next.frame_tick = 1'b1;
      st_next.samp_cnt = 4'h0;
    end
    else
      st_next.frame_cnt = st_reg.frame_cnt + 10'h001;
    // Lane GPIO samples per frame, taken on bit strobes and not exact cycle counts
    if (st_reg.bit_strobe && (st_reg.samp_cnt < samples_per_frame(mode_now))
      && !st_next.frame_tick) // RULE10
    begin
      st_next.samp_cnt = st_reg.samp_cnt + 4'h1; // RULE9
      st_next.gpio_valid = !(spi_fwd_on || spi_rev_on);
      st_next.gpio_sample = (fast_gpio ? GPIO_SEC_IN : GPIO_PRI_IN) & lane_mask(mode_now); // RULE8
    end
    // Normal content only in normal mode
    st_next.send_status = (mode_now == bgst_pkg::BGST_NORMAL); // RULE6 RULE23
    // Local GPIO drive for both lanes
    for (int k = 0; k < 4; k++)
    begin
      st_next.pri_oe[k] = nib_oe(lane_nib(st_reg.cfg_pri, k)); // RULE12 RULE24
      st_next.pri_out[k] = lane_nib(st_reg.cfg_pri, k) == bgst_pkg::CFG_OUT_HIGH;
      st_next.sec_oe[k] = nib_oe(lane_nib(st_reg.cfg_sec, k)); // RULE24
      st_next.sec_out[k] = lane_nib(st_reg.cfg_sec, k) == bgst_pkg::CFG_OUT_HIGH;
      st_next.reg_oe[k] = nib_oe(st_reg.cfg_reg[k / 2][4 * (k % 2) +: 4]); // RULE11
      st_next.reg_out[k] = st_reg.cfg_reg[k / 2][4 * (k % 2) +: 4] == bgst_pkg::CFG_OUT_HIGH;
      st_next.audio_ovr[k] = nib_used(st_reg.cfg_reg[k / 2][4 * (k % 2) +: 4]); // RULE11
    end
    st_next.g9_oe = nib_oe(st_reg.cfg9[3:0]); // RULE12
    st_next.g9_out = st_reg.cfg9[3:0] == bgst_pkg::CFG_OUT_HIGH;
    // Forward SPI: one sample per forward frame, clock one cycle behind data
    if (spi_fwd_on)
    begin
      if (FWD_FRAME_VALID) // RULE21
      begin
        st_next.spi_pico = FWD_SPI_PICO;
        st_next.spi_sel_n = FWD_SPI_SEL_N;
        st_next.spi_clk_pre = FWD_SPI_CLK;
      end
      st_next.spi_clk = st_reg.spi_clk_pre; // RULE22
      if (!st_reg.spi_clk)
        st_next.link_poci = SPI_POCI; // RULE22
    end
    else
    begin
      st_next.spi_pico = 1'b0;
      st_next.spi_sel_n = 1'b1;
      st_next.spi_clk_pre = 1'b0;
      st_next.spi_clk = 1'b0;
      st_next.link_poci = 1'b0;
    end
    // Reverse SPI select sent once per frame, so a high lasts a whole frame
    if (!spi_rev_on)
      st_next.rev_sel_n = 1'b1;
    else if (st_next.frame_tick)
      st_next.rev_sel_n = REV_SPI_SEL_N; // RULE25
  end

  // State register with synchronous reset
  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      st_reg <= '0;
      st_reg.port_sel <= bgst_pkg::RST_PORT_SELECT;
      st_reg.mode <= bgst_pkg::RST_SIDE_CHANNEL_MODE;
      st_reg.spi_sel_n <= 1'b1;
      st_reg.rev_sel_n <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  // Ports straight from the state register; config bytes leave the block only through REG_RDATA
  assign REG_RDATA = st_reg.rdata;
  assign REG_RVALID = st_reg.rvalid;
  assign GPIO_PRI_OUT = st_reg.pri_out;
  assign GPIO_PRI_OE = st_reg.pri_oe;
  assign GPIO_SEC_OUT = st_reg.sec_out;
  assign GPIO_SEC_OE = st_reg.sec_oe;
  assign GPIO_REG_OUT = st_reg.reg_out; // RULE15
  assign GPIO_REG_OE = st_reg.reg_oe;
  assign AUDIO_IN_OVERRIDE = st_reg.audio_ovr;
  assign GPIO9_OUT = st_reg.g9_out;
  assign GPIO9_OE = st_reg.g9_oe;
  assign BC_BIT_STROBE = st_reg.bit_strobe;
  assign BC_FRAME_TICK = st_reg.frame_tick;
  assign BC_SEND_STATUS = st_reg.send_status;
  assign BC_GPIO_SAMPLE = st_reg.gpio_sample;
  assign BC_GPIO_VALID = st_reg.gpio_valid;
  assign SPI_CLK = st_reg.spi_clk;
  assign SPI_PICO = st_reg.spi_pico;
  assign SPI_SEL_N = st_reg.spi_sel_n;
  assign LINK_POCI = st_reg.link_poci;
  assign BC_REV_SEL_N = st_reg.rev_sel_n;

  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  sequence hs_on_s;
    st_reg.highspeed && st_reg.strap_done;
  endsequence
  sequence strobe_pair_s;
    BC_BIT_STROBE ##1 !BC_BIT_STROBE ##1 BC_BIT_STROBE;
  endsequence
  sequence after_release_s;
    $fell(RESET) ##1 1'b1;
  endsequence

  AST_SLOW_DIV: assert property (!st_reg.highspeed && !st_reg.rate_sel // RULE1 RULE2
    && BC_BIT_STROBE && $stable(st_reg.highspeed) |=> !BC_BIT_STROBE [*3])
    else $error("Slow rate strobe spacing wrong");
  AST_MID_DIV: assert property (!st_reg.highspeed && st_reg.rate_sel // RULE1 RULE2
    && $stable(st_reg.rate_sel) && BC_BIT_STROBE |=> !BC_BIT_STROBE)
    else $error("Mid rate strobe spacing wrong");
  AST_FAST_DIV: assert property (hs_on_s ##1 hs_on_s ##1 hs_on_s |-> BC_BIT_STROBE) // RULE3
    else $error("High speed strobe not every cycle");
  AST_STRAP: assert property (after_release_s |-> // RULE4
    st_reg.highspeed == $past(STRAP_HIGHSPEED))
    else $error("Strap not loaded");
  AST_STATUS_CONTENT: assert property (BC_SEND_STATUS |-> // RULE6
    $past(mode_now) == bgst_pkg::BGST_NORMAL)
    else $error("Status sent in fast mode");
  AST_FAST1_MASK: assert property (BC_GPIO_VALID // RULE8
    && $past(mode_now) == bgst_pkg::BGST_FAST1 |-> BC_GPIO_SAMPLE[3:1] == 3'h0)
    else $error("Single lane sample carries other lanes");
  AST_GPIO9_DRIVE: assert property ($past(st_reg.cfg9[3:0]) == bgst_pkg::CFG_OUT_HIGH // RULE12
    |-> GPIO9_OE && GPIO9_OUT)
    else $error("GPIO9 high drive missing");
  AST_READ_ANSWER: assert property (REG_RD |=> REG_RVALID) // RULE13
    else $error("Read not answered next cycle");
  AST_SPI_CLK_LAG: assert property (spi_fwd_on && $past(spi_fwd_on) |=> // RULE22
    SPI_CLK == $past(st_reg.spi_clk_pre))
    else $error("Regenerated clock not one cycle late");
  AST_POCI_HOLD: assert property (spi_fwd_on && SPI_CLK |=> $stable(LINK_POCI)) // RULE22
    else $error("Peripheral-out moved while clock high");
  AST_SPI_LANE: assert property (!DUAL_LANE |=> SPI_SEL_N && !SPI_CLK) // RULE16
    else $error("SPI active without dual lane");
  AST_REV_SEL: assert property ($rose(BC_REV_SEL_N) && spi_rev_on |-> BC_FRAME_TICK) // RULE25
    else $error("Reverse select changed off frame");
  AST_STROBES: assert property (strobe_pair_s |-> st_reg.rate_sel || st_reg.highspeed // RULE1
    || !$stable(st_reg.rate_sel))
    else $error("Strobe spacing two at slow rate");
endmodule
